// file: shared/irq_vec_pkg.sv
package irq_vec_pkg;

  // ---------------------------------------------------------------
  // register map (index on the register port)
  // ---------------------------------------------------------------
  localparam logic [2:0] ADDR_CONTROL  = 3'h0;
  localparam logic [2:0] ADDR_RESETCTL = 3'h1;
  localparam logic [2:0] ADDR_FLAGS    = 3'h2;
  localparam logic [2:0] ADDR_ENABLES  = 3'h3;
  localparam logic [2:0] ADDR_PRIORITY = 3'h4;
  localparam logic [2:0] ADDR_STATUS   = 3'h5;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_HIGH_GLOBAL  = 7;
  localparam int BIT_LOW_GLOBAL   = 6;
  localparam int BIT_PRIO_FEATURE = 7;
  localparam int BIT_IN_LOW       = 0;
  localparam int BIT_IN_HIGH      = 1;

  // ---------------------------------------------------------------
  // reset values and vectors
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_CONTROL  = 8'h00;
  localparam logic [7:0]  RST_RESETCTL = 8'h00;
  localparam logic [7:0]  RST_FLAGS    = 8'h00;
  localparam logic [7:0]  RST_ENABLES  = 8'h00;
  localparam logic [7:0]  RST_PRIORITY = 8'hFF;
  localparam logic [20:0] VEC_HIGH     = 21'h000008;
  localparam logic [20:0] VEC_LOW      = 21'h000018;

  // cycles from pin edge to flag set: two sync stages plus the flag register
  localparam int PIN_SYNC_STAGES = 2;

endpackage

// file: hw/irq_pin_sync.sv
`timescale 1ns/10ps
module irq_pin_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk_sys_in,
  input  wire logic             reset_n_in,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] rise_out,
  output logic      [WIDTH-1:0] change_out
);

  // ---------------------------------------------------------------
  // two-stage synchroniser, then edge detection on the clean level
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] prev_r;

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end
    else
    begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign rise_out   = sync_r & ~prev_r;
  assign change_out = sync_r ^ prev_r;

endmodule // irq_pin_sync

// file: hw/irq_level_select.sv
`timescale 1ns/10ps
module irq_level_select #(
  parameter int N = 8
) (
  input  wire logic [N-1:0] flags_in,
  input  wire logic [N-1:0] enables_in,
  input  wire logic [N-1:0] priority_in,
  input  wire logic [N-1:0] periph_mask_in,
  input  wire logic         prio_mode_in,
  input  wire logic         high_global_in,
  input  wire logic         low_global_in,
  output logic              high_req_out,
  output logic              low_req_out
);

  // ---------------------------------------------------------------
  // per-source eligibility
  // ---------------------------------------------------------------
  logic [N-1:0] hi_ok;
  logic [N-1:0] lo_ok;

  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_src
      wire armed   = flags_in[i] & enables_in[i];
      wire grp_ok  = ~periph_mask_in[i] | low_global_in;
      wire compat  = armed & high_global_in & grp_ok;
      wire pr_high = armed & priority_in[i] & high_global_in;
      wire pr_low  = armed & ~priority_in[i] & high_global_in
                     & low_global_in;
      assign hi_ok[i] = prio_mode_in ? pr_high : compat;
      assign lo_ok[i] = prio_mode_in & pr_low;
    end
  endgenerate

  assign high_req_out = |hi_ok;
  assign low_req_out  = |lo_ok;

endmodule // irq_level_select

// file: hw/irq_vector_ctrl.sv
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/10ps
module irq_vector_ctrl #(
  parameter int         N_PINS      = 3,
  parameter int         N_PORT      = 4,
  parameter logic [7:0] PERIPH_MASK = 8'hF0
) (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_n_in,
  input  wire logic [2:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [7:0]  reg_rdata_out,
  input  wire logic [7:0]  src_event_in,
  input  wire logic [N_PINS-1:0] ext_pin_in,
  input  wire logic [N_PORT-1:0] change_port_in,
  input  wire logic        instr_boundary_in,
  input  wire logic        return_instr_in,
  output logic             vector_take_out,
  output logic             push_return_out,
  output logic      [20:0] program_counter_load_out
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]  control_r;
  logic [7:0]  control_nxt;
  logic [7:0]  resetctl_r;
  logic [7:0]  flags_r;
  logic [7:0]  flags_nxt;
  logic [7:0]  enables_r;
  logic [7:0]  priority_r;
  logic        in_high_r;
  logic        in_high_nxt;
  logic        in_low_r;
  logic        in_low_nxt;
  logic        take_r;
  logic [20:0] vector_r;
  logic [7:0]  rdata_r;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire wr_control  = reg_wr_in && reg_addr_in == irq_vec_pkg::ADDR_CONTROL;
  wire wr_resetctl = reg_wr_in
                     && reg_addr_in == irq_vec_pkg::ADDR_RESETCTL;
  wire wr_flags    = reg_wr_in && reg_addr_in == irq_vec_pkg::ADDR_FLAGS;
  wire wr_enables  = reg_wr_in && reg_addr_in == irq_vec_pkg::ADDR_ENABLES;
  wire wr_priority = reg_wr_in
                     && reg_addr_in == irq_vec_pkg::ADDR_PRIORITY;

  wire prio_mode   = resetctl_r[irq_vec_pkg::BIT_PRIO_FEATURE];
  wire high_global = control_r[irq_vec_pkg::BIT_HIGH_GLOBAL];
  wire low_global  = control_r[irq_vec_pkg::BIT_LOW_GLOBAL];

  // ---------------------------------------------------------------
  // event capture: pins synchronised, edges become flag sets
  // ---------------------------------------------------------------
  logic [N_PINS+N_PORT-1:0] pin_rise;
  logic [N_PINS+N_PORT-1:0] pin_change;

  irq_pin_sync #(
    .WIDTH      (N_PINS + N_PORT)
  ) u_pin_sync (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .pin_in     ({change_port_in, ext_pin_in}),
    .rise_out   (pin_rise),
    .change_out (pin_change)
  );

  wire        port_change = |pin_change[N_PINS+N_PORT-1:N_PINS];
  wire [7:0]  pin_set     = 8'({port_change, pin_rise[N_PINS-1:0]});
  wire [7:0]  flag_set    = src_event_in | pin_set;

  // ---------------------------------------------------------------
  // eligibility and selection
  // ---------------------------------------------------------------
  logic high_req;
  logic low_req;

  irq_level_select #(
    .N              (8)
  ) u_level_select (
    .flags_in       (flags_r),
    .enables_in     (enables_r),
    .priority_in    (priority_r),
    .periph_mask_in (PERIPH_MASK),
    .prio_mode_in   (prio_mode),
    .high_global_in (high_global),
    .low_global_in  (low_global),
    .high_req_out   (high_req),
    .low_req_out    (low_req)
  );

  wire take_now  = instr_boundary_in && (high_req || low_req);
  wire take_high = take_now && high_req;
  wire take_low  = take_now && !high_req;
  wire [20:0] vec_sel = (take_high || !prio_mode) ?
                        irq_vec_pkg::VEC_HIGH :
                        irq_vec_pkg::VEC_LOW;

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb
  begin
    // flags: software write, then hardware sets win over clears
    flags_nxt = wr_flags ? reg_wdata_in : flags_r;
    flags_nxt = flags_nxt | flag_set;

    control_nxt = wr_control ? reg_wdata_in : control_r;
    in_high_nxt = in_high_r;
    in_low_nxt  = in_low_r;

    // return restores the enable that entry cleared
    if (return_instr_in)
    begin
      if (in_high_r)
      begin
        control_nxt[irq_vec_pkg::BIT_HIGH_GLOBAL] = 1'b1;
        in_high_nxt = 1'b0;
      end
      else if (in_low_r)
      begin
        control_nxt[irq_vec_pkg::BIT_LOW_GLOBAL] = 1'b1;
        in_low_nxt = 1'b0;
      end
    end

    // entry clears the applicable global enable
    if (take_high)
    begin
      control_nxt[irq_vec_pkg::BIT_HIGH_GLOBAL] = 1'b0;
      in_high_nxt = 1'b1;
    end
    else if (take_low)
    begin
      control_nxt[irq_vec_pkg::BIT_LOW_GLOBAL] = 1'b0;
      in_low_nxt = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      control_r  <= irq_vec_pkg::RST_CONTROL;
      resetctl_r <= irq_vec_pkg::RST_RESETCTL;
      flags_r    <= irq_vec_pkg::RST_FLAGS;
      enables_r  <= irq_vec_pkg::RST_ENABLES;
      priority_r <= irq_vec_pkg::RST_PRIORITY;
      in_high_r  <= 1'b0;
      in_low_r   <= 1'b0;
    end
    else
    begin
      control_r  <= control_nxt;
      flags_r    <= flags_nxt;
      in_high_r  <= in_high_nxt;
      in_low_r   <= in_low_nxt;
      if (wr_resetctl)
        resetctl_r <= reg_wdata_in & 8'h80;
      if (wr_enables)
        enables_r <= reg_wdata_in;
      if (wr_priority)
        priority_r <= reg_wdata_in;
    end
  end

  // ---------------------------------------------------------------
  // sequencer hand-off
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      take_r   <= 1'b0;
      vector_r <= irq_vec_pkg::VEC_HIGH;
    end
    else
    begin
      take_r <= take_now;
      if (take_now)
        vector_r <= vec_sel;
    end
  end

  assign vector_take_out          = take_r;
  assign push_return_out          = take_r;
  assign program_counter_load_out = vector_r;

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  wire [7:0] status_val = 8'({in_high_r, in_low_r});
  logic [7:0] rd_mux;

  always_comb
  begin
    case (reg_addr_in)
      irq_vec_pkg::ADDR_CONTROL:  rd_mux = control_r;
      irq_vec_pkg::ADDR_RESETCTL: rd_mux = resetctl_r;
      irq_vec_pkg::ADDR_FLAGS:    rd_mux = flags_r;
      irq_vec_pkg::ADDR_ENABLES:  rd_mux = enables_r;
      irq_vec_pkg::ADDR_PRIORITY: rd_mux = priority_r;
      irq_vec_pkg::ADDR_STATUS:   rd_mux = status_val;
      default:                    rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      rdata_r <= 8'h00;
    else
      rdata_r <= reg_rd_in ? rd_mux : 8'h00;
  end

  assign reg_rdata_out = rdata_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);

  a_high_vector_addr: assert property (
    instr_boundary_in && high_req && prio_mode
    |=> vector_take_out
        && program_counter_load_out == irq_vec_pkg::VEC_HIGH)
    else $error("high request did not vector to high address");

  a_low_vector_addr: assert property (
    instr_boundary_in && !high_req && low_req && prio_mode
    |=> vector_take_out
        && program_counter_load_out == irq_vec_pkg::VEC_LOW)
    else $error("low request did not vector to low address");

  a_compat_vector: assert property (
    take_now && !prio_mode
    |=> program_counter_load_out == irq_vec_pkg::VEC_HIGH)
    else $error("compatibility vector not the single vector");

  a_entry_clear_high: assert property (
    take_high && !wr_control
    |=> !control_r[irq_vec_pkg::BIT_HIGH_GLOBAL] && in_high_r)
    else $error("entry did not clear high global enable");

  a_entry_clear_low: assert property (
    take_low && !wr_control
    |=> !control_r[irq_vec_pkg::BIT_LOW_GLOBAL]
        && $stable(control_r[irq_vec_pkg::BIT_HIGH_GLOBAL]))
    else $error("low entry touched the wrong enable");

  a_boundary_only: assert property (
    !instr_boundary_in |=> !vector_take_out)
    else $error("vector taken outside an instruction boundary");

  a_flag_set_wins: assert property (
    flag_set != 8'h00 |=> (flags_r & $past(flag_set)) == $past(flag_set))
    else $error("flag event lost");

  a_return_restore: assert property (
    return_instr_in && in_high_r && !take_now && !wr_control
    |=> control_r[irq_vec_pkg::BIT_HIGH_GLOBAL] && !in_high_r)
    else $error("return did not restore high global enable");

  a_enable_blocks: assert property (
    enables_r == 8'h00 |-> !high_req && !low_req)
    else $error("disabled source requested a vector");

  a_pin_latency: assert property (
    $rose(pin_rise[0]) |=> flags_r[0])
    else $error("pin edge did not set its flag");

  c_high_take: cover property (take_high && prio_mode);
  c_low_take: cover property (take_low);
  c_preempt: cover property (take_high && in_low_r);
  c_compat_take: cover property (take_now && !prio_mode);

endmodule // irq_vector_ctrl

// file: sim/core_seq_model.sv
`timescale 1ns/10ps
module core_seq_model (
  input  wire logic clk_sys_in,
  input  wire logic reset_n_in,
  input  wire logic two_cycle_in,
  input  wire logic ret_req_in,
  input  wire logic vector_take_in,
  output logic      instr_boundary_out,
  output logic      return_instr_out
);
  // ----
  // instruction sequencer
  // ----
  logic [1:0] phase_r;
  logic       ret_pend_r;

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      phase_r            <= 2'h0;
      ret_pend_r         <= 1'b0;
      instr_boundary_out <= 1'b0;
      return_instr_out   <= 1'b0;
    end
    else
    begin
      ret_pend_r         <= ret_pend_r | ret_req_in;
      instr_boundary_out <= 1'b0;
      return_instr_out   <= 1'b0;
      // entering the vector costs three cycles with no boundary
      if (vector_take_in)
        phase_r <= 2'h2;
      else if (phase_r != 2'h0)
        phase_r <= phase_r - 2'h1;
      else
      begin
        phase_r            <= {1'b0, two_cycle_in};
        instr_boundary_out <= 1'b1;
        return_instr_out   <= ret_pend_r;
        ret_pend_r         <= ret_req_in;
      end
    end
  end
endmodule // core_seq_model

// file: sim/test_two_level_interrupt_vectoring.sv
`timescale 1ns/10ps
module test_two_level_interrupt_vectoring;
  localparam logic [2:0]  A_CTL = irq_vec_pkg::ADDR_CONTROL;
  localparam logic [2:0]  A_RST = irq_vec_pkg::ADDR_RESETCTL;
  localparam logic [2:0]  A_FLG = irq_vec_pkg::ADDR_FLAGS;
  localparam logic [2:0]  A_ENA = irq_vec_pkg::ADDR_ENABLES;
  localparam logic [2:0]  A_PRI = irq_vec_pkg::ADDR_PRIORITY;
  localparam logic [2:0]  A_STS = irq_vec_pkg::ADDR_STATUS;
  localparam logic [20:0] VH    = irq_vec_pkg::VEC_HIGH;
  localparam logic [20:0] VL    = irq_vec_pkg::VEC_LOW;
  logic        clk;
  logic        rst_n;
  logic [2:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic [7:0]  ev;
  logic [2:0]  pins;
  logic [3:0]  port;
  logic        boundary;
  logic        ret;
  logic        ret_req;
  logic        two_cyc;
  logic        take;
  logic        push;
  logic [20:0] pc;
  logic        rd_seen;
  logic [7:0]  exp_rd_q[$];
  logic [20:0] exp_vec_q[$];
  int          fails;
  int          comparisons;
  int          cyc = 0;
  int          take_cyc;
  int          t0;
  logic [31:0] seed;
  logic [7:0]  v;
  logic [7:0]  rst_tbl [0:6];

  irq_vector_ctrl dut (
    .clk_sys_in              (clk),
    .reset_n_in              (rst_n),
    .reg_addr_in             (addr),
    .reg_wdata_in            (wdata),
    .reg_wr_in               (wr),
    .reg_rd_in               (rd),
    .reg_rdata_out           (rdata),
    .src_event_in            (ev),
    .ext_pin_in              (pins),
    .change_port_in          (port),
    .instr_boundary_in       (boundary),
    .return_instr_in         (ret),
    .vector_take_out         (take),
    .push_return_out         (push),
    .program_counter_load_out(pc)
  );

  core_seq_model core (
    .clk_sys_in        (clk),
    .reset_n_in        (rst_n),
    .two_cycle_in      (two_cyc),
    .ret_req_in        (ret_req),
    .vector_take_in    (take),
    .instr_boundary_out(boundary),
    .return_instr_out  (ret)
  );

  initial clk = 1'b0;
  always #5 clk = ~clk;

  // ----
  // checks and bus tasks
  // ----
  task automatic chk8(input string n, input logic [7:0] e,
                      input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk21(input string n, input logic [20:0] e,
                       input logic [20:0] g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    // control words are written by one plain write strobe
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
    exp_rd_q.push_back(e);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(posedge clk);
  endtask

  task automatic pulse(input logic [7:0] m);
    ev <= m;
    @(posedge clk);
    ev <= 8'h00;
    @(posedge clk);
  endtask

  task automatic ret_do();
    ret_req <= 1'b1;
    @(posedge clk);
    ret_req <= 1'b0;
    repeat (5) @(posedge clk);
  endtask

  // waits out any pending take; an unexpected one is caught by the monitor
  task automatic settle();
    int n;
    n = 0;
    repeat (8) @(posedge clk);
    while (exp_vec_q.size() + exp_rd_q.size() != 0 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 40)
    begin
      fails++;
      $display("CHECK FAILED take expected %h seen none", exp_vec_q[0]);
      exp_vec_q.delete();
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----
  // monitor and timeout
  // ----
  always @(posedge clk)
  begin
    cyc     <= cyc + 1;
    rd_seen <= rd;
    if (rd_seen === 1'b1)
      chk8("rdata", exp_rd_q.pop_front(), rdata);
    if (take === 1'b1)
    begin
      take_cyc = cyc;
      chk8("push", 8'h01, {7'h00, push});
      if (exp_vec_q.size() == 0)
        chk21("vector", 21'h1FFFFF, pc);
      else
        chk21("vector", exp_vec_q.pop_front(), pc);
    end
    if (cyc > 3000)
    begin
      fails++;
      wrap_up();
    end
  end

  initial
  begin
    seed    = 32'h968C1F0E;
    fails   = 0;
    comparisons = 0;
    rst_n   = 1'b0;
    addr    = 3'h0;
    wdata   = 8'h00;
    wr      = 1'b0;
    rd      = 1'b0;
    ev      = 8'h00;
    pins    = 3'h0;
    port    = 4'h0;
    ret_req = 1'b0;
    two_cyc = 1'b0;
    rst_tbl = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 7; i++)
      rd_reg(i[2:0], rst_tbl[i]);
    v = 8'($random(seed));
    pulse(v);
    rd_reg(A_FLG, v);
    wr_reg(A_PRI, v);
    rd_reg(A_PRI, v);
    wr_reg(A_FLG, 8'h00);
    rd_reg(A_FLG, 8'h00);
    $display("done: reset values and flags");
    wr_reg(A_ENA, 8'h11);
    wr_reg(A_CTL, 8'h80);
    pulse(8'h10);
    settle();
    exp_vec_q.push_back(VH);
    pulse(8'h01);
    settle();
    rd_reg(A_CTL, 8'h00);
    wr_reg(A_FLG, 8'h10);
    ret_do();
    rd_reg(A_CTL, 8'h80);
    exp_vec_q.push_back(VH);
    wr_reg(A_CTL, 8'hC0);
    settle();
    rd_reg(A_CTL, 8'h40);
    wr_reg(A_FLG, 8'h00);
    ret_do();
    wr_reg(A_ENA, 8'h00);
    pulse(8'h11);
    settle();
    rd_reg(A_FLG, 8'h11);
    $display("done: compatibility mode");
    two_cyc <= 1'b1;
    wr_reg(A_RST, 8'h80);
    wr_reg(A_PRI, 8'h01);
    wr_reg(A_FLG, 8'h00);
    wr_reg(A_ENA, 8'h03);
    wr_reg(A_CTL, 8'h80);
    exp_vec_q.push_back(VH);
    pulse(8'h03);
    settle();
    rd_reg(A_CTL, 8'h00);
    rd_reg(A_STS, 8'h02);
    wr_reg(A_FLG, 8'h02);
    ret_do();
    settle();
    exp_vec_q.push_back(VL);
    wr_reg(A_CTL, 8'hC0);
    settle();
    rd_reg(A_CTL, 8'h80);
    rd_reg(A_STS, 8'h01);
    exp_vec_q.push_back(VH);
    pulse(8'h01);
    settle();
    rd_reg(A_CTL, 8'h00);
    rd_reg(A_STS, 8'h03);
    wr_reg(A_FLG, 8'h00);
    ret_do();
    rd_reg(A_CTL, 8'h80);
    ret_do();
    rd_reg(A_CTL, 8'hC0);
    // both levels eligible at once: high first, low waits
    exp_vec_q.push_back(VH);
    pulse(8'h03);
    settle();
    rd_reg(A_CTL, 8'h40);
    rd_reg(A_STS, 8'h02);
    exp_vec_q.push_back(VL);
    wr_reg(A_FLG, 8'h02);
    ret_do();
    settle();
    rd_reg(A_CTL, 8'h80);
    rd_reg(A_STS, 8'h01);
    wr_reg(A_FLG, 8'h00);
    ret_do();
    rd_reg(A_CTL, 8'hC0);
    $display("done: priority mode");
    two_cyc <= 1'b0;
    wr_reg(A_RST, 8'h00);
    wr_reg(A_ENA, 8'h09);
    wr_reg(A_CTL, 8'h80);
    for (int k = 0; k < 2; k++)
    begin
      exp_vec_q.push_back(VH);
      t0 = cyc;
      if (k == 0)
        pins <= 3'h1;
      else
        port <= 4'h1;
      settle();
      chk8("latency", 8'h01, {7'h00, (take_cyc - t0) inside {[3:6]}});
      wr_reg(A_FLG, 8'h00);
      ret_do();
    end
    $display("done: pin latency");
    wrap_up();
  end
endmodule // test_two_level_interrupt_vectoring
